/* dac_cmd_consts.vh */
/*
 constants for the serial converter command interface: word layout,
 control codes, register map and timing counts.
 assumes inclusion by bare name from the design files.
*/
`ifndef DAC_CMD_CONSTS_VH
`define DAC_CMD_CONSTS_VH

`define WORD_BITS        16
`define CODE_BITS        12
`define CTRL_HI          15
`define CTRL_LO          13
`define CODE_HI          12
`define CODE_LO          1
`define SUB_BIT_POS      0

`define CMD_LOAD_UPDATE  2'h0
`define CMD_LOAD_BUFFER  2'h1
`define CMD_UPDATE       2'h2
`define CMD_SHUTDOWN     3'h7

`define ADDR_CONTROL     8'h00
`define ADDR_STATUS      8'h04
`define ADDR_BUFFER      8'h08
`define ADDR_CONVERTER   8'h0C
`define ADDR_WORD        8'h10
`define CTRL_RESET       32'h00000000
`define CTRL_EN_BIT      0

`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`define CLK_PERIOD_NS    50
`define SETTLE_TIME_NS   20000
`define SETTLE_CYCLES    ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* pin_sync.v */
/*
 two flip-flop synchroniser for a group of pin levels.
 assumes the pins are asynchronous to ref_clk; the first stage is read
 only by the second.
*/
`timescale 1ns/10ps
module pin_sync #(
   parameter WIDTH = 3,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   input  wire             ref_clk,   // sampling clock
   input  wire             srst,      // sync reset, active high
   input  wire             clk_en,    // freezes state when low
   input  wire [WIDTH-1:0] pins_in,   // raw pins
   output reg  [WIDTH-1:0] pins_out   // synchronised levels
);
   reg [WIDTH-1:0] meta_ff;

   // two stages; reset value keeps the idle level of each pin
   always @(posedge ref_clk) begin
      if (srst) begin
         meta_ff  <= INIT;
         pins_out <= INIT;
      end else if (clk_en) begin
         meta_ff  <= pins_in;
         pins_out <= meta_ff;
      end
   end
endmodule // pin_sync

/* shift_word.v */
/*
 16-bit serial shift register with bit counter, msb first.
 assumes synchronised select and a one-cycle rising-edge strobe of the
 shift clock, both on ref_clk.
*/
`timescale 1ns/10ps
`include "dac_cmd_consts.vh"
module shift_word #(
   parameter WORD_BITS = `WORD_BITS
) (
   input  wire                 ref_clk,     // clock
   input  wire                 srst,        // sync reset
   input  wire                 clk_en,      // clock enable
   input  wire                 sel_active,  // select low, synchronised
   input  wire                 sclk_rise,   // shift clock rising strobe
   input  wire                 din_lvl,     // data level
   output reg  [WORD_BITS-1:0] word_ff,     // shifted word
   output reg  [4:0]           count_ff     // bits taken, saturates
);
   // shift only while selected; a fresh frame restarts the count
   always @(posedge ref_clk) begin
      if (srst) begin
         word_ff  <= {WORD_BITS{1'b0}};
         count_ff <= 5'h00;
      end else if (clk_en) begin
         if (!sel_active) begin
            count_ff <= 5'h00;
         end else if (sclk_rise) begin
            word_ff  <= {word_ff[WORD_BITS-2:0], din_lvl};
            if (count_ff != 5'h1F)
               count_ff <= count_ff + 5'h01;
         end
      end
   end
endmodule // shift_word

/* serial_dac_command_interface.v */
/*
 command front end of a 12-bit voltage-output converter: serial link
 receiver, command decode, double-buffered code registers, shutdown,
 and an axi4-lite slave for observation and control.
 assumes link pins are asynchronous to ref_clk (20 MHz) and the shift
 clock runs well below a quarter of ref_clk so every edge is seen.
*/
`timescale 1ns/10ps
`include "dac_cmd_consts.vh"
module serial_dac_command_interface #(
   parameter CODE_BITS     = `CODE_BITS,
   parameter SETTLE_CYCLES = `SETTLE_CYCLES
) (
   input  wire                 ref_clk,        // 20 MHz clock
   input  wire                 srst,           // sync reset, active high
   input  wire                 clk_en,         // freezes all state when low
   input  wire                 sel_n,          // link select, active low
   input  wire                 sclk,           // link shift clock
   input  wire                 sdin,           // link serial data
   output reg  [CODE_BITS-1:0] dac_code,       // converter register
   output reg                  out_drive_en,   // analog output driven
   output reg                  ref_input_en,   // scale input enabled
   output reg                  output_settled, // settle time elapsed
   input  wire [7:0]           s_axi_awaddr,   // write address
   input  wire                 s_axi_awvalid,  // write address valid
   output reg                  s_axi_awready,  // write address ready
   input  wire [31:0]          s_axi_wdata,    // write data
   input  wire [3:0]           s_axi_wstrb,    // write strobes
   input  wire                 s_axi_wvalid,   // write data valid
   output reg                  s_axi_wready,   // write data ready
   output reg  [1:0]           s_axi_bresp,    // write response
   output reg                  s_axi_bvalid,   // write response valid
   input  wire                 s_axi_bready,   // write response ready
   input  wire [7:0]           s_axi_araddr,   // read address
   input  wire                 s_axi_arvalid,  // read address valid
   output reg                  s_axi_arready,  // read address ready
   output reg  [31:0]          s_axi_rdata,    // read data
   output reg  [1:0]           s_axi_rresp,    // read response
   output reg                  s_axi_rvalid,   // read data valid
   input  wire                 s_axi_rready    // read data ready
);
   localparam [1:0] ST_IDLE  = 2'h0;
   localparam [1:0] ST_FRAME = 2'h1;
   localparam [2:0] SYNC_INIT = 3'h6; // select high, clock high, data low

   wire [2:0]  pins_lvl;
   wire        sel_lvl_n = pins_lvl[2];
   wire        sclk_lvl  = pins_lvl[1];
   wire        din_lvl   = pins_lvl[0];
   wire [15:0] word;
   wire [4:0]  bit_count;

   reg [1:0]           state_ff;
   reg [1:0]           nxt_state;
   reg                 sclk_prev_ff;
   reg [CODE_BITS-1:0] buffer_ff;
   reg [CODE_BITS-1:0] conv_ff;
   reg                 shutdown_ff;
   reg                 link_en_ff;
   reg [15:0]          last_word_ff;
   reg [7:0]           frames_ok_ff;
   reg [7:0]           frames_bad_ff;
   reg [15:0]          settle_cnt_ff;
   reg                 aw_got_ff;
   reg                 w_got_ff;
   reg [7:0]           aw_addr_ff;
   reg [31:0]          w_data_ff;
   reg [3:0]           w_strb_ff;

   // link pins are foreign to ref_clk: two stages before any use
   pin_sync #(
      .WIDTH (3),
      .INIT  (SYNC_INIT)
   ) u_pin_sync (
      .ref_clk  (ref_clk),
      .srst     (srst),
      .clk_en   (clk_en),
      .pins_in  ({sel_n, sclk, sdin}),
      .pins_out (pins_lvl)
   );

   // serial logic disabled while select high or link disabled by software
   wire sel_active = ~sel_lvl_n & link_en_ff;
   wire sclk_rise  = sclk_lvl & ~sclk_prev_ff;

   shift_word #(
      .WORD_BITS (`WORD_BITS)
   ) u_shift_word (
      .ref_clk    (ref_clk),
      .srst       (srst),
      .clk_en     (clk_en),
      .sel_active (sel_active),
      .sclk_rise  (sclk_rise),
      .din_lvl    (din_lvl),
      .word_ff    (word),
      .count_ff   (bit_count)
   );

   // frame tracker: end of frame is the select rising edge
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE:  if (sel_active) nxt_state = ST_FRAME;
         ST_FRAME: if (!sel_active) nxt_state = ST_IDLE;
         default:  nxt_state = ST_IDLE;
      endcase
   end

   wire frame_end = (state_ff == ST_FRAME) & ~sel_active;
   wire frame_ok  = frame_end & (bit_count == 5'h10);

   // field split of the word
   wire [2:0]           ctrl_code = word[`CTRL_HI:`CTRL_LO];
   wire [CODE_BITS-1:0] code_bits = word[`CODE_HI:`CODE_LO];
   wire                 sub_bit   = word[`SUB_BIT_POS];

   wire is_shutdown = (ctrl_code == `CMD_SHUTDOWN);
   wire is_load_upd = (ctrl_code[1:0] == `CMD_LOAD_UPDATE);
   wire is_load_buf = (ctrl_code[1:0] == `CMD_LOAD_BUFFER);
   wire is_update   = (ctrl_code[1:0] == `CMD_UPDATE);
   wire wake        = frame_ok & (is_load_upd | is_update);

   // clock edge finder and frame state
   always @(posedge ref_clk) begin
      if (srst) begin
         sclk_prev_ff <= 1'b1;
         state_ff     <= ST_IDLE;
      end else if (clk_en) begin
         sclk_prev_ff <= sclk_lvl;
         state_ff     <= nxt_state;
      end
   end

   // double-buffered code registers and shutdown; 011 matches nothing
   always @(posedge ref_clk) begin
      if (srst) begin
         buffer_ff   <= {CODE_BITS{1'b0}};
         conv_ff     <= {CODE_BITS{1'b0}};
         shutdown_ff <= 1'b0;
      end else if (clk_en && frame_ok) begin
         if (is_load_upd) begin
            buffer_ff   <= code_bits;
            conv_ff     <= code_bits;
            shutdown_ff <= 1'b0;
         end else if (is_load_buf) begin
            buffer_ff <= code_bits;
         end else if (is_update) begin
            conv_ff     <= buffer_ff;
            shutdown_ff <= 1'b0;
         end else if (is_shutdown) begin
            shutdown_ff <= 1'b1;
         end
      end
   end

   // frame log for software; the last word kept even if malformed
   always @(posedge ref_clk) begin
      if (srst) begin
         last_word_ff  <= 16'h0000;
         frames_ok_ff  <= 8'h00;
         frames_bad_ff <= 8'h00;
      end else if (clk_en && frame_end) begin
         last_word_ff <= word;
         if (frame_ok)
            frames_ok_ff <= frames_ok_ff + 8'h01;
         else
            frames_bad_ff <= frames_bad_ff + 8'h01;
      end
   end

   // settle timer restarts on reset release and on each wake while in shutdown
   always @(posedge ref_clk) begin
      if (srst) begin
         settle_cnt_ff <= 16'h0000;
      end else if (clk_en) begin
         if (wake && shutdown_ff)
            settle_cnt_ff <= 16'h0000;
         else if (settle_cnt_ff != SETTLE_CYCLES[15:0])
            settle_cnt_ff <= settle_cnt_ff + 16'h0001;
      end
   end

   // pin outputs from flops; analog ends float during shutdown
   always @(posedge ref_clk) begin
      if (srst) begin
         dac_code       <= {CODE_BITS{1'b0}};
         out_drive_en   <= 1'b1;
         ref_input_en   <= 1'b1;
         output_settled <= 1'b0;
      end else if (clk_en) begin
         dac_code       <= conv_ff;
         out_drive_en   <= ~shutdown_ff;
         ref_input_en   <= ~shutdown_ff;
         output_settled <= ~shutdown_ff & (settle_cnt_ff == SETTLE_CYCLES[15:0]);
      end
   end

   // axi4-lite write: address and data taken in either order
   wire do_write = aw_got_ff & w_got_ff & ~s_axi_bvalid;
   always @(posedge ref_clk) begin
      if (srst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         aw_got_ff     <= 1'b0;
         w_got_ff      <= 1'b0;
         aw_addr_ff    <= 8'h00;
         w_data_ff     <= 32'h00000000;
         w_strb_ff     <= 4'h0;
         link_en_ff    <= 1'b1;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_ff    <= s_axi_awaddr;
            aw_got_ff     <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_ff    <= s_axi_wdata;
            w_strb_ff    <= s_axi_wstrb;
            w_got_ff     <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            if (aw_addr_ff[7:2] == `ADDR_CONTROL >> 2) begin
               if (w_strb_ff[0])
                  link_en_ff <= w_data_ff[`CTRL_EN_BIT];
               s_axi_bresp <= `RESP_OKAY;
            end else if (aw_addr_ff[7:2] <= `ADDR_WORD >> 2) begin
               s_axi_bresp <= `RESP_OKAY;   // read-only: write ignored
            end else begin
               s_axi_bresp <= `RESP_SLVERR;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_got_ff     <= 1'b0;
            w_got_ff      <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // axi4-lite read: one cycle after address, held until rready
   always @(posedge ref_clk) begin
      if (srst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `RESP_OKAY;
            if (s_axi_araddr[7:2] == `ADDR_CONTROL >> 2)
               s_axi_rdata <= {31'h0, link_en_ff};
            else if (s_axi_araddr[7:2] == `ADDR_STATUS >> 2)
               s_axi_rdata <= {frames_bad_ff, frames_ok_ff, 12'h000, bit_count[3:0] == 4'h0 ? 1'b0 : 1'b1,
                               output_settled, sel_active, shutdown_ff};
            else if (s_axi_araddr[7:2] == `ADDR_BUFFER >> 2)
               s_axi_rdata <= {20'h00000, buffer_ff};
            else if (s_axi_araddr[7:2] == `ADDR_CONVERTER >> 2)
               s_axi_rdata <= {20'h00000, conv_ff};
            else if (s_axi_araddr[7:2] == `ADDR_WORD >> 2)
               s_axi_rdata <= {16'h0000, last_word_ff};
            else begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= `RESP_SLVERR;
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule // serial_dac_command_interface

/* dac_cmd_chk.sv */
/*
 checker for the converter command front end: link timing of register
 updates, shutdown enables, reset state and axi read answers.
 assumes it is bound onto the top module and sees only its ports.
*/
`timescale 1ns/10ps
module dac_cmd_chk #(
   parameter CODE_BITS = 12
) (
   input wire                 ref_clk,        // clock
   input wire                 srst,           // sync reset
   input wire                 clk_en,         // clock enable
   input wire                 sel_n,          // link select pin
   input wire [CODE_BITS-1:0] dac_code,       // converter register
   input wire                 out_drive_en,   // output driven
   input wire                 ref_input_en,   // scale input on
   input wire                 output_settled, // settle flag
   input wire [7:0]           s_axi_araddr,   // read address
   input wire                 s_axi_arvalid,  // read address valid
   input wire                 s_axi_arready,  // read address ready
   input wire [31:0]          s_axi_rdata,    // read data
   input wire [1:0]           s_axi_rresp,    // read response
   input wire                 s_axi_rvalid    // read valid
);
   reg       sel_q_ff;
   reg [3:0] since_ff;

   // cycles since the select pin rose; saturates so stale rises never match
   always @(posedge ref_clk) begin
      sel_q_ff <= sel_n;
      if (srst)
         since_ff <= 4'hF;
      else if (sel_n && !sel_q_ff)
         since_ff <= 4'h0;
      else if (clk_en && since_ff != 4'hF)
         since_ff <= since_ff + 4'h1;
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   code_after_rise_a: assert property ($changed(dac_code) |-> since_ff inside {[2:10]})
      else $error("converter code moved without a select rise");
   wake_after_rise_a: assert property ($rose(out_drive_en) |-> since_ff inside {[2:10]})
      else $error("output woke without a select rise");
   enables_match_a: assert property (out_drive_en == ref_input_en)
      else $error("output and scale enables differ");
   reset_state_a: assert property ($fell(srst) |-> dac_code == 0 && out_drive_en && !output_settled)
      else $error("wrong state after reset");
   settle_delay_a: assert property ($rose(output_settled) |-> $past(out_drive_en, 8))
      else $error("settled flag rose too soon");
   settled_off_a: assert property ((!out_drive_en) [*2] |-> !output_settled)
      else $error("settled flag high in shutdown");
   shutdown_code_a: assert property ($fell(out_drive_en) |-> $stable(dac_code))
      else $error("shutdown altered the converter code");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("read not answered");
   unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h13
      |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0))
      else $error("unmapped read not refused");
endmodule // dac_cmd_chk

bind serial_dac_command_interface dac_cmd_chk #(.CODE_BITS(CODE_BITS)) dac_cmd_chk_i (
   .ref_clk, .srst, .clk_en, .sel_n, .dac_code, .out_drive_en, .ref_input_en, .output_settled,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid);

/* link_host.sv */
/*
 host side of the serial link: frames of selectable length, msb first.
 assumes the bench calls send and waits for it; clock idles low.
*/
`timescale 1ns/10ps
module link_host (
   output reg sel_n, // select, active low
   output reg sclk,  // shift clock, 400 ns period
   output reg sdin   // serial data
);
   initial begin
      sel_n = 1'h1;
      sclk = 1'h0;
      sdin = 1'h0;
   end

   // ghost keeps select high to show the pins are ignored then
   task send(input [15:0] w, input integer nb, input split, input ghost);
      integer i;
      begin
         // step off the ref_clk edge so pin changes never race the sampler
         #12;
         sel_n = ghost;
         #100;
         for (i = 0; i < nb; i = i + 1) begin
            sdin = (i >= 15) ? 1'h0 : w[15-i];
            #100 sclk = 1'h1;
            #200 sclk = 1'h0;
            #100;
            if (split && i == 7)
               #800;
         end
         #100 sel_n = 1'h1;
         // released data line must not keep its last level
         sdin = ~sdin;
         #400;
      end
   endtask
endmodule // link_host

/* tb.sv */
/*
 self-checking bench for the converter command front end.
 assumes link_host drives the link and the checker is bound in.
*/
`timescale 1ns/10ps
`include "dac_cmd_consts.vh"
module tb;
   reg         ref_clk = 1'h0;
   reg         srst = 1'h1;
   reg         clk_en = 1'h1;
   reg  [7:0]  s_axi_awaddr = 8'h00;
   reg  [31:0] s_axi_wdata = 32'h0;
   reg  [3:0]  s_axi_wstrb = 4'hF;
   reg  [7:0]  s_axi_araddr = 8'h00;
   reg         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   reg         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   wire        sel_n, sclk, sdin, out_drive_en, ref_input_en, output_settled;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [11:0] dac_code;
   integer     mismatches = 0, cmp_count = 0, i, nb, k;
   reg  [31:0] s, d;
   reg  [11:0] eb, ed;
   reg  [2:0]  c;
   reg  [1:0]  r;
   reg         sd, wake, ok;

   // 20 MHz clock
   always #25 ref_clk = ~ref_clk;

   link_host link_host_i (.sel_n, .sclk, .sdin);
   serial_dac_command_interface #(.SETTLE_CYCLES(20)) serial_dac_command_interface_i (
      .ref_clk, .srst, .clk_en, .sel_n, .sclk, .sdin, .dac_code, .out_drive_en, .ref_input_en,
      .output_settled, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   // random source and expected converter code
   function [31:0] lfsr(input [31:0] x);
      lfsr = {x[30:0], 1'h0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
   endfunction
   function [11:0] nxt_dac(input [2:0] cc, input [11:0] code, input [11:0] b, input [11:0] dd);
      nxt_dac = (cc[1:0] == 2'h0) ? code : (cc[1:0] == 2'h2) ? b : dd;
   endfunction

   // four-state compare, so unknowns never pass
   task chk(input [31:0] got, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask

   // bus cycles start one edge in, so a strobe is never set twice at once
   task axi_wr(input [7:0] a, input [31:0] v, output [1:0] rsp);
      begin
         @(posedge ref_clk);
         s_axi_awaddr <= a;
         s_axi_wdata <= v;
         s_axi_awvalid <= 1'h1;
         s_axi_wvalid <= 1'h1;
         s_axi_bready <= 1'h1;
         ok = 1'h0;
         while (!ok) begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) begin
               rsp = s_axi_bresp;
               s_axi_bready <= 1'h0;
               ok = 1'h1;
            end
         end
      end
   endtask
   task axi_rd(input [7:0] a, output [31:0] v, output [1:0] rsp);
      begin
         @(posedge ref_clk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'h1;
         s_axi_rready <= 1'h1;
         ok = 1'h0;
         while (!ok) begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) begin
               v = s_axi_rdata;
               rsp = s_axi_rresp;
               s_axi_rready <= 1'h0;
               ok = 1'h1;
            end
         end
      end
   endtask

   // state right after a reset release
   task reset_chk;
      begin
         chk(dac_code, 32'h0);
         chk(out_drive_en, 32'h1);
         axi_rd(`ADDR_BUFFER, d, r);
         chk(d, 32'h0);
         eb = 12'h0;
         ed = 12'h0;
         sd = 1'h0;
      end
   endtask

   task conclude;
      begin
         $display("comparisons=%0d mismatches=%0d", cmp_count, mismatches);
         if (mismatches == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask

   // every control code, split, short, long and deselected frames
   initial begin
      s = 32'h884CA0A5;
      repeat (3) @(posedge ref_clk);
      srst <= 1'h0;
      repeat (3) @(posedge ref_clk);
      reset_chk;
      for (i = 0; i < 24; i = i + 1) begin
         s = lfsr(s);
         k = (i < 16) ? i * 3 : i * 5;
         c = k[2:0];
         nb = (i == 4) ? 9 : (i == 10) ? 17 : 16;
         link_host_i.send({c, s[11:0], 1'h0}, nb, i[0], i == 12);
         repeat (4) @(posedge ref_clk);
         wake = 1'h0;
         if (nb == 16 && i != 12) begin
            wake = sd && !c[0];
            ed = nxt_dac(c, s[11:0], eb, ed);
            if (!c[1]) eb = s[11:0];
            if (!c[0]) sd = 1'h0;
            else if (c == 3'h7) sd = 1'h1;
         end
         chk(dac_code, ed);
         chk(out_drive_en, !sd);
         chk(ref_input_en, !sd);
         if (wake) chk(output_settled, 32'h0);
         axi_rd(`ADDR_BUFFER, d, r);
         chk(d[11:0], eb);
         axi_rd(`ADDR_STATUS, d, r);
         chk(d[0], sd);
         repeat (24) @(posedge ref_clk);
         chk(output_settled, !sd);
      end
      // refused places on the bus
      axi_rd(8'h40, d, r);
      chk(r, `RESP_SLVERR);
      axi_wr(8'h80, 32'h1, r);
      chk(r, `RESP_SLVERR);
      // link switched off: a load must not land
      axi_wr(`ADDR_CONTROL, 32'h0, r);
      link_host_i.send({3'h0, ~ed, 1'h0}, 16, 1'h0, 1'h0);
      repeat (4) @(posedge ref_clk);
      chk(dac_code, ed);
      axi_wr(`ADDR_CONTROL, 32'h1, r);
      axi_rd(`ADDR_CONTROL, d, r);
      chk(d, 32'h1);
      clk_en <= 1'h0;
      repeat (10) @(posedge ref_clk);
      clk_en <= 1'h1;
      // full-scale code, then a reset in mid-run
      link_host_i.send({3'h4, 12'hFFF, 1'h0}, 16, 1'h0, 1'h0);
      repeat (4) @(posedge ref_clk);
      chk(dac_code, 32'hFFF);
      srst <= 1'h1;
      repeat (3) @(posedge ref_clk);
      srst <= 1'h0;
      repeat (3) @(posedge ref_clk);
      reset_chk;
      conclude;
   end

   // cut a hang short
   initial begin
      #2000000;
      mismatches = mismatches + 1;
      conclude;
   end
endmodule // tb
